//--- design/smfp_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SMFP_REGS_SVH
`define SMFP_REGS_SVH
`define SMFP_ADDR_W 16
`define SMFP_OFF_CTRLA 16'h0331
`define SMFP_OFF_CTRLB 16'h0332
`define SMFP_OFF_STORM 16'h0333
`define SMFP_OFF_STAT 16'h0337
`define SMFP_RST_CTRLA 8'hF0
`define SMFP_RST_CTRLB 8'h00
`define SMFP_RST_STORM 8'h4A
`define SMFP_A_MCEXCL 6
`define SMFP_A_BPCS 5
`define SMFP_A_FAIR 4
`define SMFP_A_NOXCOL 3
`define SMFP_A_JUMBO 2
`define SMFP_A_NOOVS 1
`define SMFP_A_SHORT 0
`define SMFP_B_NULLVID 3
`define SMFP_STORM_UNIT 64
`define SMFP_XCOL_LIMIT 16
`define SMFP_LEN_OVS 2000
`define SMFP_LEN_TAG 1522
`define SMFP_LEN_UNTAG 1518
`define SMFP_LEN_MIN 64
`define SMFP_LEN_SHORT 32
`define SMFP_JUMBO_MAX 9000
`define SMFP_CLK_MHZ 100
`define SMFP_PER_G_MS 5
`define SMFP_PER_M_MS 50
`define SMFP_PER_T_MS 500
`endif

//--- design/smfp_pkg.sv
// Types shared by the frame policy block
package smfp_pkg;
   // Port speed of the frame source
   typedef enum logic [1:0] {
      SMFP_SPD_10 = 2'h0,
      SMFP_SPD_100 = 2'h1,
      SMFP_SPD_1000 = 2'h3
   } smfp_speed_t;
   // Back pressure method
   typedef enum logic {SMFP_BP_COLLISION = 1'b0, SMFP_BP_CARRIER = 1'b1}
      smfp_bp_t;
endpackage

//--- design/smfp_frame_policy.sv
// Frame admission, storm policing and back pressure policy
`timescale 1ns/1ps
`default_nettype none
`include "smfp_regs.svh"

// Functional notes
// R1 - Multicast excluded from storm count when set
// R2 - Bit five selects carrier or collision backpressure
// R3 - Fair mode may drop non-flow-controlled frames
// R4 - Fair off: never drop non-flow-controlled frames
// R5 - Drop after sixteen collisions unless disabled
// R6 - Software should pair with alternate back-off
// R7 - Jumbo accepts up to payload limit, max 9000
// R8 - Jumbo overrides oversize check disable
// R9 - Oversize disabled accepts up to 2000 bytes
// R10 - Standard sizes 1522 tagged, 1518 untagged
// R11 - Short pass accepts 32 to 64 bytes
// R12 - Otherwise frames under 64 bytes dropped
// R13 - Null VID replaced by port default VID
// R14 - Storm limit eleven bits split over two bytes
// R15 - Budget is storm limit times 64 bytes
// R16 - Period 5, 50 or 500 ms by speed
// R17 - Storm limit resets to 0x4A, upper zero
// R18 - Alternate back-off acts in half duplex only
// R19 - Over budget drops storm frames until period end
// R20 - Reserved bits store writes, no effect
module smfp_frame_policy #(
   parameter int PERIOD_G_CYC = `SMFP_PER_G_MS * 1000 * `SMFP_CLK_MHZ,
   parameter int PERIOD_M_CYC = `SMFP_PER_M_MS * 1000 * `SMFP_CLK_MHZ,
   parameter int PERIOD_T_CYC = `SMFP_PER_T_MS * 1000 * `SMFP_CLK_MHZ
) (
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Register port
   input wire logic [15:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   // Port configuration, same clock
   input wire smfp_pkg::smfp_speed_t portSpeed,
   input wire logic halfDuplex,
   input wire logic altBackoff,
   input wire logic [13:0] jumboLimit,
   input wire logic [11:0] portDefVid,
   // Frame check request, one cycle
   input wire logic frmValid,
   input wire logic [13:0] frmLen,
   input wire logic frmTagged,
   input wire logic frmBcast,
   input wire logic frmMcast,
   input wire logic [11:0] frmVid,
   input wire logic frmFlowCtl,
   input wire logic egrCongested,
   input wire logic [4:0] frmCollisions,
   // Verdict, one cycle later
   output logic verdictValid,
   output logic frmAccept,
   output logic [11:0] outVid,
   // Back pressure controls
   output logic bpCarrierMode,
   output logic altBackoffOn
);
   import smfp_pkg::*;

   //////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] ctrlA_q, ctrlA_d; // Policy control byte A
   logic [7:0] ctrlB_q, ctrlB_d; // Policy control byte B
   logic [7:0] storm_q, storm_d; // Storm limit low byte
   logic [7:0] rd_q, rd_d; // Read data
   logic stormHit_q, stormHit_d; // Sticky over-budget seen

   // Register write and read decode
   always_comb begin
      ctrlA_d = ctrlA_q;
      ctrlB_d = ctrlB_q;
      storm_d = storm_q;
      rd_d = 8'h00;
      // R20 reserved bits stored
      if (regWrite) begin
         unique case (regAddr)
            `SMFP_OFF_CTRLA: ctrlA_d = regWrData;
            `SMFP_OFF_CTRLB: ctrlB_d = regWrData;
            `SMFP_OFF_STORM: storm_d = regWrData;
            default: ;
         endcase
      end
      if (regRead) begin
         unique case (regAddr)
            `SMFP_OFF_CTRLA: rd_d = ctrlA_q;
            `SMFP_OFF_CTRLB: rd_d = ctrlB_q;
            `SMFP_OFF_STORM: rd_d = storm_q;
            `SMFP_OFF_STAT: rd_d = {7'h00, stormHit_q};
            default: rd_d = 8'h00;
         endcase
      end
   end

   // Register storage
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ctrlA_q <= `SMFP_RST_CTRLA;
         ctrlB_q <= `SMFP_RST_CTRLB;
         // R17 storm reset value
         storm_q <= `SMFP_RST_STORM;
         rd_q <= 8'h00;
      end else begin
         ctrlA_q <= ctrlA_d;
         ctrlB_q <= ctrlB_d;
         storm_q <= storm_d;
         rd_q <= rd_d;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Storm period and budget
   logic [31:0] perCnt_q, perCnt_d; // Period timer
   logic [19:0] used_q, used_d; // Storm bytes this period
   logic [10:0] stormLimit; // Eleven bit limit
   logic [19:0] budget; // Bytes allowed per period
   logic [31:0] perLen; // Period length in cycles
   logic perEnd; // Period boundary
   logic stormFrm; // Frame counts toward storm
   logic overBudget; // Budget exceeded

   // Period length by speed
   function automatic logic [31:0] period_cycles(input smfp_speed_t s);
      unique case (s)
         SMFP_SPD_1000: period_cycles = 32'(PERIOD_G_CYC);
         SMFP_SPD_100: period_cycles = 32'(PERIOD_M_CYC);
         default: period_cycles = 32'(PERIOD_T_CYC);
      endcase
   endfunction

   always_comb begin
      // R14 limit assembly
      stormLimit = {ctrlB_q[2:0], storm_q};
      // R15 byte budget
      budget = 20'(stormLimit) * 20'(`SMFP_STORM_UNIT);
      // R16 speed dependent period
      perLen = period_cycles(portSpeed);
      perEnd = (perCnt_q >= perLen - 32'h1);
      // R1 multicast exclusion
      stormFrm = frmBcast | (frmMcast & ~ctrlA_q[`SMFP_A_MCEXCL]);
      overBudget = (used_q > budget);
      perCnt_d = perEnd ? 32'h0 : perCnt_q + 32'h1;
      used_d = used_q;
      stormHit_d = stormHit_q;
      // R19 count and reset at boundary
      if (frmValid && stormFrm && !overBudget) begin
         used_d = used_q + 20'(frmLen);
      end
      if (perEnd) begin
         used_d = 20'h0;
      end
      if (frmValid && stormFrm && overBudget) begin
         stormHit_d = 1'b1;
      end
      if (regRead && regAddr == `SMFP_OFF_STAT && !stormHit_d) begin
         stormHit_d = 1'b0;
      end else if (regRead && regAddr == `SMFP_OFF_STAT
                   && !(frmValid && stormFrm && overBudget)) begin
         stormHit_d = 1'b0;
      end
   end

   // Storm state registers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         perCnt_q <= 32'h0;
         used_q <= 20'h0;
         stormHit_q <= 1'b0;
      end else begin
         perCnt_q <= perCnt_d;
         used_q <= used_d;
         stormHit_q <= stormHit_d;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Frame admission
   logic lenOk; // Length within window
   logic [13:0] maxLen; // Largest allowed length
   logic xcolDrop; // Excessive collision drop
   logic fairDrop; // Fair mode drop
   logic vOut_q, vOut_d; // Verdict strobe
   logic acc_q, acc_d; // Accept verdict
   logic [11:0] vid_q, vid_d; // Output VID
   logic bp_q, bp_d; // Carrier mode flag
   logic alt_q, alt_d; // Alternate back-off active

   always_comb begin
      // R8 jumbo takes precedence
      // R7 jumbo payload limit
      if (ctrlA_q[`SMFP_A_JUMBO]) begin
         maxLen = (jumboLimit > 14'(`SMFP_JUMBO_MAX)) ?
                  14'(`SMFP_JUMBO_MAX) : jumboLimit;
      // R9 relaxed oversize limit
      end else if (ctrlA_q[`SMFP_A_NOOVS]) begin
         maxLen = 14'(`SMFP_LEN_OVS);
      // R10 standard limits
      end else begin
         maxLen = frmTagged ? 14'(`SMFP_LEN_TAG) : 14'(`SMFP_LEN_UNTAG);
      end
      // R11 R12 short frame window
      lenOk = (frmLen <= maxLen) &&
              (ctrlA_q[`SMFP_A_SHORT] ? frmLen >= 14'(`SMFP_LEN_SHORT)
                                      : frmLen >= 14'(`SMFP_LEN_MIN));
      // R5 excessive collisions
      xcolDrop = !ctrlA_q[`SMFP_A_NOXCOL] &&
                 frmCollisions >= 5'(`SMFP_XCOL_LIMIT);
      // R3 R4 fair mode drop
      fairDrop = ctrlA_q[`SMFP_A_FAIR] && !frmFlowCtl && egrCongested;
      vOut_d = frmValid;
      acc_d = frmValid && lenOk && !xcolDrop && !fairDrop &&
              !(stormFrm && overBudget);
      // R13 null VID replacement
      vid_d = (ctrlB_q[`SMFP_B_NULLVID] && frmVid == 12'h000) ?
              portDefVid : frmVid;
      // R2 back pressure style
      bp_d = ctrlA_q[`SMFP_A_BPCS];
      // R18 half duplex only
      alt_d = altBackoff && halfDuplex;
   end

   // Verdict registers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         vOut_q <= 1'b0;
         acc_q <= 1'b0;
         vid_q <= 12'h000;
         bp_q <= 1'b1;
         alt_q <= 1'b0;
      end else begin
         vOut_q <= vOut_d;
         acc_q <= acc_d;
         vid_q <= vid_d;
         bp_q <= bp_d;
         alt_q <= alt_d;
      end
   end

   assign regRdData = rd_q;
   assign verdictValid = vOut_q;
   assign frmAccept = acc_q;
   assign outVid = vid_q;
   assign bpCarrierMode = bp_q;
   assign altBackoffOn = alt_q;

   //////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);

   long_drop_a: assert property ( // R10
      frmValid && !ctrlA_q[2] && !ctrlA_q[1] && !frmTagged &&
      frmLen == 14'd1519 |=> verdictValid && !frmAccept)
      else $error("untagged 1519 byte frame accepted");
   short_drop_a: assert property ( // R12
      frmValid && !ctrlA_q[0] && frmLen == 14'd63 |=> !frmAccept)
      else $error("63 byte frame accepted without short pass");
   ovs_len_a: assert property ( // R9
      frmValid && ctrlA_q[2:1] == 2'b01 && frmLen == 14'd2001
      |=> !frmAccept)
      else $error("2001 byte frame accepted");
   xcol_drop_a: assert property ( // R5
      frmValid && !ctrlA_q[3] && frmCollisions >= 5'd16 |=> !frmAccept)
      else $error("excess collision frame accepted");
   null_vid_a: assert property ( // R13
      frmValid && ctrlB_q[3] && frmVid == 12'h000
      |=> outVid == $past(portDefVid))
      else $error("null VID not replaced");
   fair_keep_a: assert property ( // R4
      frmValid && !ctrlA_q[4] && ctrlA_q[3] && lenOk && !stormFrm
      |=> frmAccept)
      else $error("frame dropped with fair mode off");
   storm_reset_a: assert property ( // R19
      perEnd |=> used_q == 20'h0)
      else $error("storm count not cleared at period end");
   mc_excl_a: assert property ( // R1
      frmValid && frmMcast && !frmBcast && ctrlA_q[6]
      |=> used_q == $past(used_q) || $past(perEnd))
      else $error("multicast counted while excluded");
   bp_mode_a: assert property ( // R2
      ##1 bpCarrierMode == $past(ctrlA_q[5]))
      else $error("back pressure mode mismatch");
   read_a: assert property ( // R17
      regRead && regAddr == 16'h0333 |=> regRdData == $past(storm_q))
      else $error("storm low byte read mismatch");
   stat_set_a: assert property ( // R19
      frmValid && stormFrm && overBudget |=> stormHit_q)
      else $error("storm drop not flagged in status");
   jumbo_cap_a: assert property ( // R7
      frmValid && ctrlA_q[2] && frmLen == 14'h2329 |=> !frmAccept)
      else $error("frame beyond jumbo cap accepted");

   storm_hit_c: cover property (frmValid && stormFrm && overBudget);
   jumbo_c: cover property (frmValid && ctrlA_q[2] && frmLen > 14'd2000);
   short_c: cover property (frmValid && ctrlA_q[0] && frmLen == 14'd40);
   nullvid_c: cover property (frmValid && ctrlB_q[3] && frmVid == 12'h0);
   fair_drop_c: cover property (frmValid && fairDrop);
endmodule
`default_nettype wire

//--- bench/smfp_link_partner.sv
// Link partner model issuing frame check requests
`timescale 1ns/1ps
`default_nettype none
module smfp_link_partner (
   // Clock
   input wire logic clock,
   // Frame check request
   output logic frmValid,
   output logic [13:0] frmLen,
   output logic frmTagged,
   output logic frmBcast,
   output logic frmMcast,
   output logic [11:0] frmVid,
   output logic frmFlowCtl,
   output logic egrCongested,
   output logic [4:0] frmCollisions
);
   // Idle line at time zero
   initial begin
      {frmValid, frmLen, frmTagged, frmBcast, frmMcast} = '0;
      {frmVid, frmFlowCtl, egrCongested, frmCollisions} = '0;
   end
   // One-cycle request; length and VID turn to junk once released
   task automatic send(logic [13:0] l, logic t, b, m, logic [11:0] v,
                       logic [4:0] c, logic f, g);
      @(posedge clock);
      frmValid <= 1'b1;
      frmLen <= l;
      {frmTagged, frmBcast, frmMcast, frmFlowCtl, egrCongested} <=
         {t, b, m, f, g};
      frmVid <= v;
      frmCollisions <= c;
      @(posedge clock);
      frmValid <= 1'b0;
      frmLen <= ~l;
      frmVid <= ~v;
   endtask
endmodule
`default_nettype wire

//--- bench/smfp_frame_policy_tb_top.sv
// Testbench for the frame policy block
`timescale 1ns/1ps
`default_nettype none
module smfp_frame_policy_tb_top;
   import smfp_pkg::*;
   logic clock = 0, arst_n = 0, regWrite = 0, regRead = 0;
   logic halfDuplex = 0, altBackoff = 0;
   logic [15:0] regAddr = '0;
   logic [7:0] regWrData = '0, shA = 8'hF0, shB = 8'h00;
   logic [13:0] jumboLimit = 14'd9500; // Above the cap on purpose
   logic [11:0] defVid = 12'h123;
   smfp_speed_t spd = SMFP_SPD_1000;
   wire logic frmValid, frmTagged, frmBcast, frmMcast, frmFlowCtl, egrCong;
   wire logic [13:0] frmLen;
   wire logic [11:0] frmVid;
   wire logic [4:0] frmCol;
   logic [7:0] regRdData;
   logic verdictValid, frmAccept, bpCarrierMode, altBackoffOn;
   logic [11:0] outVid;
   int n_errors = 0, checks_done = 0, cyc = 0;
   logic [7:0] cfgs[5] = '{8'hE0, 8'hE1, 8'hE2, 8'hE4, 8'hE6};
   int lens[12] = '{31, 32, 63, 64, 1518, 1519, 1522, 1523, 2000, 2001,
                    9000, 9001};
   logic [7:0] cfg2[3] = '{8'hE0, 8'hE8, 8'hF0};
   int cmb[4][3] = '{'{15, 1, 1}, '{16, 1, 0}, '{0, 0, 1}, '{0, 1, 1}};
   int probes[3] = '{450, 900, 1500};
   ////////////////////////////////////////////////////////////////////
   // Clock and cycle count since reset release
   initial begin
      forever #5 clock = ~clock;
   end
   always @(posedge clock) cyc <= arst_n ? cyc + 1 : 0;
   smfp_link_partner lp (.clock(clock), .frmValid(frmValid),
      .frmLen(frmLen), .frmTagged(frmTagged), .frmBcast(frmBcast),
      .frmMcast(frmMcast), .frmVid(frmVid), .frmFlowCtl(frmFlowCtl),
      .egrCongested(egrCong), .frmCollisions(frmCol));
   smfp_frame_policy #(.PERIOD_G_CYC(300), .PERIOD_M_CYC(600),
      .PERIOD_T_CYC(1200)) dut (.clock(clock), .arst_n(arst_n),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
      .regRead(regRead), .regRdData(regRdData), .portSpeed(spd),
      .halfDuplex(halfDuplex), .altBackoff(altBackoff),
      .jumboLimit(jumboLimit), .portDefVid(defVid), .frmValid(frmValid),
      .frmLen(frmLen), .frmTagged(frmTagged), .frmBcast(frmBcast),
      .frmMcast(frmMcast), .frmVid(frmVid), .frmFlowCtl(frmFlowCtl),
      .egrCongested(egrCong), .frmCollisions(frmCol),
      .verdictValid(verdictValid), .frmAccept(frmAccept),
      .outVid(outVid), .bpCarrierMode(bpCarrierMode),
      .altBackoffOn(altBackoffOn));
   ////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic chk(logic [15:0] seen, logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   // Register write, shadowing the control bytes
   task automatic wr(logic [15:0] a, logic [7:0] d);
      @(posedge clock);
      {regAddr, regWrData, regWrite} <= {a, d, 1'b1};
      @(posedge clock);
      regWrite <= 1'b0;
      if (a == 16'h0331) shA = d;
      if (a == 16'h0332) shB = d;
   endtask
   // Register read, data checked in the following cycle
   task automatic rd(logic [15:0] a, logic [7:0] e);
      @(posedge clock);
      {regAddr, regRead} <= {a, 1'b1};
      @(posedge clock);
      regRead <= 1'b0;
      #1 chk({8'h00, regRdData}, {8'h00, e});
   endtask
   // Expected admission from the control byte
   function automatic logic expAcc(logic [7:0] a, int len, logic tg,
                                   int col, logic fc, logic cg);
      int mn, mx;
      mn = a[0] ? 32 : 64;
      mx = a[2] ? 9000 : a[1] ? 2000 : tg ? 1522 : 1518;
      return len >= mn && len <= mx && !(col >= 16 && !a[3])
             && !(a[4] && !fc && cg);
   endfunction
   // One frame check with verdict and tag compare
   task automatic frame(int len, logic tg, b, m, logic [11:0] v,
                        int col, logic fc, cg, ex);
      logic [11:0] ev;
      ev = (shB[3] && v == 12'h000) ? defVid : v;
      lp.send(len[13:0], tg, b, m, v, col[4:0], fc, cg);
      #1 chk({15'h0000, verdictValid}, 16'h0001);
      chk({15'h0000, frmAccept}, {15'h0000, ex});
      chk({4'h0, outVid}, {4'h0, ev});
   endtask
   // Storm budget and period, each run from a fresh reset
   task automatic storm(smfp_speed_t sp, int per);
      @(posedge clock) begin
         arst_n <= 1'b0;
         spd <= sp;
      end
      @(posedge clock) arst_n <= 1'b1;
      {shA, shB} = 16'hF000;
      wr(16'h0331, 8'hF4);
      wr(16'h0332, 8'h01);
      wr(16'h0333, 8'h00);
      frame(9000, 0, 1, 0, 12'h00A, 0, 1, 0, 1);
      frame(9000, 0, 1, 0, 12'h00A, 0, 1, 0, 1);
      frame(64, 0, 1, 0, 12'h00A, 0, 1, 0, 0);
      rd(16'h0337, 8'h01);
      rd(16'h0337, 8'h00);
      frame(64, 0, 0, 1, 12'h00A, 0, 1, 0, 1);
      wr(16'h0331, 8'hB4);
      frame(64, 0, 0, 1, 12'h00A, 0, 1, 0, 0);
      foreach (probes[i]) begin
         // Bounded wait for the probe cycle
         for (int w = 0; w < 2000 && cyc < probes[i]; w++) @(posedge clock);
         if (cyc < probes[i]) begin
            n_errors++;
            summarize();
         end
         frame(64, 0, 1, 0, 12'h00A, 0, 1, 0, probes[i] > per);
      end
   endtask
   // Verdict and end of run
   task automatic summarize();
      if (n_errors == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   // Hang guard
   initial begin
      #1000000;
      n_errors++;
      summarize();
   end
   // Main sequence
   initial begin
      repeat (6) @(posedge clock);
      arst_n <= 1'b1;
      rd(16'h0331, 8'hF0);
      rd(16'h0332, 8'h00);
      rd(16'h0333, 8'h4A);
      chk({15'h0000, bpCarrierMode}, 16'h0001);
      wr(16'h0330, 8'hFF);
      rd(16'h0330, 8'h00);
      wr(16'h0332, 8'hF5);
      rd(16'h0332, 8'hF5);
      wr(16'h0332, 8'h00);
      wr(16'h0331, 8'hC0);
      @(posedge clock) altBackoff <= 1'b1;
      repeat (2) @(posedge clock);
      #1 chk({15'h0000, bpCarrierMode}, 16'h0000);
      chk({15'h0000, altBackoffOn}, 16'h0000);
      @(posedge clock) halfDuplex <= 1'b1;
      repeat (2) @(posedge clock);
      #1 chk({15'h0000, altBackoffOn}, 16'h0001);
      foreach (cfgs[i]) begin
         wr(16'h0331, cfgs[i]);
         foreach (lens[j]) for (int t = 0; t < 2; t++) begin
            frame(lens[j], t[0], 0, 0, 12'h00A, 0, 1, 0,
                  expAcc(shA, lens[j], t[0], 0, 1, 0));
         end
      end
      foreach (cfg2[i]) begin
         wr(16'h0331, cfg2[i]);
         foreach (cmb[k]) begin
            frame(100, 0, 0, 0, 12'h00A, cmb[k][0], cmb[k][1][0],
                  cmb[k][2][0], expAcc(shA, 100, 0, cmb[k][0],
                  cmb[k][1][0], cmb[k][2][0]));
         end
      end
      // Programmable jumbo limit below the cap
      @(posedge clock) jumboLimit <= 14'd4000;
      wr(16'h0331, 8'hE4);
      frame(4000, 0, 0, 0, 12'h00A, 0, 1, 0, 1);
      frame(4001, 0, 0, 0, 12'h00A, 0, 1, 0, 0);
      @(posedge clock) jumboLimit <= 14'd9500;
      wr(16'h0332, 8'h08);
      frame(100, 1, 0, 0, 12'h000, 0, 1, 0, 1);
      frame(100, 1, 0, 0, 12'h005, 0, 1, 0, 1);
      wr(16'h0332, 8'h00);
      frame(100, 1, 0, 0, 12'h000, 0, 1, 0, 1);
      storm(SMFP_SPD_1000, 300);
      storm(SMFP_SPD_100, 600);
      storm(SMFP_SPD_10, 1200);
      summarize();
   end
endmodule
`default_nettype wire
